/* File: hw/event_log_ring_buffer.sv */
// Circular event log with timestamps, link and display read paths.
// Assumes one 40 MHz clock, an Avalon-MM master and synchronous inputs.
`timescale 1ns/10ps
`include "event_log_map.svh"

module event_log_ring_buffer
	import event_log_pkg::*;
#(
	parameter int DEPTH = 2000,          // Storage slots
	parameter int MS_DIV = `MS_CYCLES    // Cycles per millisecond
) (
	input wire logic clk,                // 40 MHz clock
	input wire logic rst_n,              // Async reset, active low
	input wire logic ev_valid,           // Event occurrence pulse
	input wire event_code_t ev_code,     // Occurring event code
	input wire logic time_synced,        // Time base is synchronized
	input wire logic [5:0] avs_address,  // Byte address
	input wire logic avs_read,           // Read request
	input wire logic avs_write,          // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata,    // Read data
	output logic avs_waitrequest,        // Stall until answered
	output logic irq,                    // Level interrupt
	output logic popup                   // Popup on new event
);

	localparam int AW = $clog2(DEPTH);

	// Storage and pointers
	event_entry_t mem_r [DEPTH];   // Entry slots
	logic [AW-1:0] wr_ptr_r;       // Next slot to write
	logic [AW-1:0] rd_ptr_r;       // Oldest unread slot
	logic [AW-1:0] disp_ptr_r;     // Display cursor
	logic [11:0] count_r;          // Stored entries
	logic [11:0] unread_r;         // Entries not yet polled
	logic [11:0] cap_r;            // Configured capacity
	logic [AW-1:0] last_r;         // Newest written slot

	// Settings
	logic scale_r;                 // 1 = primary, 0 = per_unit_scale
	logic popup_en_r;              // Popup enable
	logic syncfmt_r;               // Bracket format option
	logic [63:0] ev_mask_r;        // Per-channel event mask
	logic [`IRQ_WIDTH-1:0] irq_st_r;   // Sticky status
	logic [`IRQ_WIDTH-1:0] irq_msk_r;  // Interrupt mask

	// Time base
	logic [31:0] ms_cnt_r;         // Divider toward 1 ms
	logic [39:0] now_ms_r;         // Millisecond clock
	logic [7:0] link_hi_r;         // Stamp high bits of last link read
	logic [7:0] disp_hi_r;         // Stamp high bits of last display read

	acc_state_t acc_r;             // Bus phase
	bus_req_t req;                 // Bundled request

	// Bus write and read strobes, capacity data, event store strobe and full flag
	logic wr_go;
	logic rd_go;
	logic store;
	logic full;
	logic cap_wr;
	logic clear_go;
	logic [11:0] cap_in;

	assign req = '{avs_read, avs_write, avs_address, avs_writedata};
	// Writes commit at the edge where the master sees waitrequest low
	assign wr_go = (acc_r == ACC_ANSWER) && req.write;
	assign rd_go = (acc_r == ACC_IDLE) && req.read;
	assign cap_in = req.wdata[11:0];
	// Only legal capacities are accepted
	assign cap_wr = wr_go && req.address == `REG_CAPACITY &&
		req.wdata[31:12] == '0 &&
		cap_in >= `CAP_MIN && cap_in <= `CAP_MAX && cap_in != cap_r;
	assign clear_go = cap_wr ||
		(wr_go && req.address == `REG_CTRL && req.wdata[`CTRL_CLEAR_BIT]);
	// Masked channels never reach storage
	assign store = ev_valid && !ev_mask_r[ev_code.channel];
	assign full = (count_r == cap_r);

	// Ring step with wrap at configured capacity
	function automatic logic [AW-1:0] step(input logic [AW-1:0] p,
		input logic [11:0] cap, input logic back);
		logic [AW-1:0] top;
		top = AW'(cap - 12'd1);
		if (back) begin
			step = (p == '0) ? top : p - AW'(1);
		end else begin
			step = (p == top) ? '0 : p + AW'(1);
		end
	endfunction

	// Pack an entry into a read word
	function automatic logic [31:0] pack(input event_entry_t e,
		input logic fmt, input logic scl, input logic ovf_show);
		pack = '0;
		pack[`RD_OVF_BIT] = ovf_show && e.overflow_marker;
		pack[`RD_BRACKET_BIT] = fmt && e.unsynced;
		pack[`RD_SCALE_BIT] = scl;
		pack[27:16] = e.code;
		pack[15:0] = e.stamp_ms[15:0];
	endfunction

	// Millisecond divider and clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_r <= '0;
			now_ms_r <= '0;
		end else if (ms_cnt_r == 32'(MS_DIV - 1)) begin
			ms_cnt_r <= '0;
			now_ms_r <= now_ms_r + 40'd1;
		end else begin
			ms_cnt_r <= ms_cnt_r + 32'd1;
		end
	end

	// Entry storage; flops only, indexed by write pointer
	always_ff @(posedge clk) begin
		if (store) begin
			// A store into a full ring is the overwrite that gets marked
			mem_r[wr_ptr_r] <= '{full, !time_synced,
				ev_code, now_ms_r};
		end
	end

	// Write pointer, fill count, oldest drop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			last_r <= '0;
			count_r <= '0;
		end else if (clear_go) begin
			// Resizing loses every held event
			wr_ptr_r <= '0;
			count_r <= '0;
		end else if (store) begin
			last_r <= wr_ptr_r;
			// When full the step lands on the oldest slot, which is reused
			wr_ptr_r <= step(wr_ptr_r, cap_r, 1'b0);
			if (!full) begin
				count_r <= count_r + 12'd1;
			end
		end
	end

	// Read pointer and unread count for the link
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_r <= '0;
			unread_r <= '0;
		end else if (clear_go) begin
			rd_ptr_r <= '0;
			unread_r <= '0;
		end else begin
			logic take;
			take = rd_go && req.address == `REG_READ_NEXT &&
				unread_r != 12'd0;
			if (store && unread_r == cap_r) begin
				// Oldest unread is overwritten; skip it
				rd_ptr_r <= step(rd_ptr_r, cap_r, 1'b0);
				unread_r <= take ? unread_r - 12'd1 : unread_r;
			end else begin
				if (take) begin
					rd_ptr_r <= step(rd_ptr_r, cap_r, 1'b0);
				end
				unread_r <= unread_r + 12'(store) - 12'(take);
			end
		end
	end

	// Display cursor, free of the link pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_ptr_r <= '0;
		end else if (clear_go) begin
			disp_ptr_r <= '0;
		end else if (wr_go && req.address == `REG_DISP_CMD &&
			count_r != 12'd0) begin
			if (req.wdata[`DISP_FWD_BIT]) begin
				disp_ptr_r <= step(disp_ptr_r, cap_r, 1'b0);
			end else if (req.wdata[`DISP_BACK_BIT]) begin
				disp_ptr_r <= step(disp_ptr_r, cap_r, 1'b1);
			end
		end
	end

	// Settings and masks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_r <= `CAP_DEFAULT;
			scale_r <= 1'b0;
			popup_en_r <= 1'b0;
			syncfmt_r <= 1'b0;
			ev_mask_r <= '0;
			irq_msk_r <= '0;
		end else if (wr_go) begin
			case (req.address)
				`REG_CTRL: begin
					scale_r <= req.wdata[`CTRL_SCALE_BIT];
					popup_en_r <= req.wdata[`CTRL_POPUP_BIT];
					syncfmt_r <= req.wdata[`CTRL_SYNCFMT_BIT];
				end
				`REG_CAPACITY: begin
					if (cap_wr) begin
						cap_r <= cap_in;
					end
				end
				`REG_EVENT_MASK: begin
					ev_mask_r[31:0] <= req.wdata;
				end
				`REG_TIME_HI: begin
					ev_mask_r[63:32] <= req.wdata;
				end
				`REG_IRQ_MASK: begin
					irq_msk_r <= req.wdata[`IRQ_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky status; a new event wins over a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_st_r <= '0;
		end else begin
			logic [`IRQ_WIDTH-1:0] clr;
			logic [`IRQ_WIDTH-1:0] set;
			clr = (wr_go && req.address == `REG_IRQ_STATUS) ?
				req.wdata[`IRQ_WIDTH-1:0] : '0;
			set = '0;
			set[`IRQ_NEW_BIT] = store;
			set[`IRQ_OVF_BIT] = store && full;
			irq_st_r <= (irq_st_r & ~clr) | set;
		end
	end

	// Interrupt and popup outputs from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
			popup <= 1'b0;
		end else begin
			irq <= |(irq_st_r & irq_msk_r);
			popup <= store && popup_en_r;
		end
	end

	// Bus answer: one wait cycle then data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= ACC_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
			link_hi_r <= '0;
			disp_hi_r <= '0;
		end else begin
			case (acc_r)
				ACC_IDLE: begin
					if (req.read || req.write) begin
						acc_r <= ACC_ANSWER;
						avs_waitrequest <= 1'b0;
						avs_readdata <= '0;
						if (req.read) begin
							case (req.address)
								`REG_CTRL: avs_readdata <= {29'h0,
									syncfmt_r, popup_en_r, scale_r};
								`REG_CAPACITY: avs_readdata <= {20'h0, cap_r};
								`REG_COUNT: avs_readdata <= {20'h0, count_r};
								`REG_READ_NEXT: begin
									if (unread_r == 12'd0) begin
										avs_readdata[`RD_EMPTY_BIT] <= 1'b1;
									end else begin
										avs_readdata <= pack(mem_r[rd_ptr_r],
											syncfmt_r, scale_r, 1'b0);
										link_hi_r <= mem_r[rd_ptr_r].stamp_ms[23:16];
									end
								end
								`REG_REREAD: begin
									if (count_r == 12'd0) begin
										avs_readdata[`RD_EMPTY_BIT] <= 1'b1;
									end else begin
										avs_readdata <= pack(mem_r[last_r],
											syncfmt_r, scale_r, 1'b0);
									end
								end
								`REG_TIME_HI: avs_readdata <= {24'h0, link_hi_r};
								`REG_IRQ_STATUS: avs_readdata <= {30'h0, irq_st_r};
								`REG_IRQ_MASK: avs_readdata <= {30'h0, irq_msk_r};
								`REG_EVENT_MASK: avs_readdata <= ev_mask_r[31:0];
								`REG_DISP_DATA: begin
									avs_readdata <= pack(mem_r[disp_ptr_r],
										syncfmt_r, scale_r, 1'b1);
									disp_hi_r <= mem_r[disp_ptr_r].stamp_ms[23:16];
								end
								`REG_DISP_TIME: avs_readdata <= {24'h0, disp_hi_r};
								`REG_LINK_TIME: avs_readdata <= now_ms_r[31:0];
								default: avs_readdata <= '0;
							endcase
						end
					end
				end
				ACC_ANSWER: begin
					acc_r <= ACC_DONE;
					avs_waitrequest <= 1'b1;
				end
				ACC_DONE: begin
					acc_r <= ACC_IDLE;
				end
				default: begin
					acc_r <= ACC_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Checks
	// One link read request seen by an idle slave
	sequence s_take;
		acc_r == ACC_IDLE && req.read && req.address == `REG_READ_NEXT;
	endsequence

	// The single answer cycle and the idle gap that follows it
	sequence s_answer;
		!avs_waitrequest;
	endsequence
	sequence s_gap;
		avs_waitrequest [*2];
	endsequence

	chk_empty_keeps_ptr: assert property (
		@(posedge clk) disable iff (!rst_n)
		s_take and unread_r == 12'd0 && !store |=> $stable(rd_ptr_r))
		else $error("Empty read moved pointer");
	chk_read_advance: assert property (
		@(posedge clk) disable iff (!rst_n)
		s_take and unread_r != 12'd0 && !store && !clear_go
		|=> rd_ptr_r != $past(rd_ptr_r))
		else $error("Read did not advance");
	chk_reread_stable: assert property (
		@(posedge clk) disable iff (!rst_n)
		rd_go && req.address == `REG_REREAD && !store
		|=> $stable(rd_ptr_r))
		else $error("Reread moved pointer");
	chk_mask_drop: assert property (
		@(posedge clk) disable iff (!rst_n)
		ev_valid && ev_mask_r[ev_code.channel] && !clear_go
		|=> $stable(count_r))
		else $error("Masked event stored");
	chk_cap_bounds: assert property (
		@(posedge clk) disable iff (!rst_n)
		cap_r >= `CAP_MIN && cap_r <= `CAP_MAX)
		else $error("Capacity out of range");
	chk_resize_clear: assert property (
		@(posedge clk) disable iff (!rst_n)
		cap_wr |=> count_r == 12'd0 && unread_r == 12'd0)
		else $error("Resize kept events");
	chk_full_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		store && full && !clear_go |=> count_r == cap_r)
		else $error("Full count changed");
	chk_answer_once: assert property (
		@(posedge clk) disable iff (!rst_n)
		s_answer |=> s_gap)
		else $error("Answer not single");
	// Entry content follows the event and the clock of its cycle
	chk_entry_stored: assert property (
		@(posedge clk) disable iff (!rst_n)
		store && !clear_go |=> mem_r[last_r].code == $past(ev_code) &&
		mem_r[last_r].stamp_ms == $past(now_ms_r))
		else $error("Stored entry differs from event");
	chk_overflow_mark: assert property (
		@(posedge clk) disable iff (!rst_n)
		store && full && !clear_go |=> mem_r[last_r].overflow_marker)
		else $error("Overwrite lacks marker");
	chk_stamp_tick: assert property (
		@(posedge clk) disable iff (!rst_n)
		ms_cnt_r == 32'(MS_DIV - 1) |=> now_ms_r == $past(now_ms_r) + 40'd1)
		else $error("Millisecond clock missed a tick");
	// Display stepping must leave the link side alone
	chk_display_apart: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_go && req.address == `REG_DISP_CMD && !store
		|=> $stable(rd_ptr_r) && $stable(unread_r))
		else $error("Display step moved link pointer");
	chk_popup_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		popup == $past(store && popup_en_r))
		else $error("Popup does not follow stored event");

endmodule

/* File: hw/event_log_map.svh */
// Register map, field layout and timing constants of the event log.
// Assumes inclusion by bare name from the log module and the bench.
`ifndef EVENT_LOG_MAP_SVH
`define EVENT_LOG_MAP_SVH

// Word byte offsets
`define REG_CTRL 6'h00
`define REG_CAPACITY 6'h04
`define REG_COUNT 6'h08
`define REG_READ_NEXT 6'h0c
`define REG_REREAD 6'h10
`define REG_TIME_HI 6'h14
`define REG_IRQ_STATUS 6'h18
`define REG_IRQ_MASK 6'h1c
`define REG_EVENT_MASK 6'h20
`define REG_DISP_CMD 6'h24
`define REG_DISP_DATA 6'h28
`define REG_DISP_TIME 6'h2c
`define REG_LINK_TIME 6'h30

// Control bits
`define CTRL_SCALE_BIT 0
`define CTRL_POPUP_BIT 1
`define CTRL_SYNCFMT_BIT 2
`define CTRL_CLEAR_BIT 3

// Display command bits
`define DISP_FWD_BIT 0
`define DISP_BACK_BIT 1

// Interrupt status bits
`define IRQ_NEW_BIT 0
`define IRQ_OVF_BIT 1
`define IRQ_WIDTH 2

// Capacity limits and default
`define CAP_DEFAULT 12'd200
`define CAP_MIN 12'd50
`define CAP_MAX 12'd2000

// Millisecond tick: 1 ms at 40 MHz
`define MS_NS 1000000
`define CLK_NS 25
`define MS_CYCLES (`MS_NS / `CLK_NS)

// Read-data word layout
`define RD_EMPTY_BIT 31
`define RD_OVF_BIT 30
`define RD_BRACKET_BIT 29
`define RD_SCALE_BIT 28

`endif

/* File: hw/event_log_pkg.sv */
// Types shared by the event log design.
// Assumes the map header is on the include path.
package event_log_pkg;
	// Event code: channel then number within channel
	typedef struct packed {
		logic [5:0] channel;  // Event channel
		logic [5:0] number;   // Event number in channel
	} event_code_t;

	// One stored entry: code and millisecond timestamp
	typedef struct packed {
		logic overflow_marker;  // Entry stored after a forced drop
		logic unsynced;         // Time base not synchronized at capture
		event_code_t code;      // Event code
		logic [39:0] stamp_ms;  // Milliseconds since reset
	} event_entry_t;

	// Bus request bundle
	typedef struct packed {
		logic read;          // Read strobe
		logic write;         // Write strobe
		logic [5:0] address; // Byte address
		logic [31:0] wdata;  // Write data
	} bus_req_t;

	// Slave access phase
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_ANSWER,
		ACC_DONE
	} acc_state_t;
endpackage

/* File: testbench/poll_master.sv */
// Polling supervisor model: an Avalon-MM master reading the event log.
// Assumes one caller at a time and a slave with waitrequest.
`timescale 1ns/10ps

module poll_master (
	input wire logic clk,                 // Clock
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest,     // Slave stall
	output logic [5:0] avs_address,       // Byte address
	output logic avs_read,                // Read request
	output logic avs_write,               // Write request
	output logic [31:0] avs_writedata     // Write data
);
	int timeouts = 0; // Answers that never came

	// Idle bus at time zero
	initial begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end

	// One bus cycle; the bench calls it through its rd and wr tasks
	task automatic xfer(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		// Hold until waitrequest is seen low; bounded so a hang ends
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 50) timeouts++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released data shows the inverted value, not the last value
		avs_writedata <= ~d;
	endtask
endmodule

/* File: testbench/event_log_ring_buffer_tb.sv */
// Self-checking bench of the event log ring buffer.
// Assumes the design package and the polling master model.
`timescale 1ns/10ps
`include "event_log_map.svh"

module event_log_ring_buffer_tb;
	import event_log_pkg::*;
	localparam int MSD = 4; // Short millisecond keeps runs brief
	localparam logic [31:0] EMPTY = 32'h80000000; // Empty read word
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ev_valid = 1'b0;
	event_code_t ev_code = '0;
	logic time_synced = 1'b1;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic popup;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0; // Free cycle counter for stamp checks
	logic [31:0] q; // Last read word
	logic pop; // Popup seen after last event

	// 40 MHz clock
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	event_log_ring_buffer #(.DEPTH(2000), .MS_DIV(MSD))
		i_event_log_ring_buffer (
		.clk(clk), .rst_n(rst_n), .ev_valid(ev_valid), .ev_code(ev_code),
		.time_synced(time_synced), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .popup(popup));

	poll_master i_poll_master (
		.clk(clk), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata));

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd(input logic [5:0] a);
		i_poll_master.xfer(1'b0, a, 32'h0, q);
		// A bus that never answers ends the run at once
		if (i_poll_master.timeouts != 0) end_of_test;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] x;
		i_poll_master.xfer(1'b1, a, d, x);
		if (i_poll_master.timeouts != 0) end_of_test;
	endtask

	// One event pulse, then watch three cycles for the popup
	task automatic ev(input logic [5:0] ch, input logic [5:0] nb);
		int i;
		@(posedge clk);
		ev_valid <= 1'b1;
		ev_code <= {ch, nb};
		@(posedge clk);
		ev_valid <= 1'b0;
		pop = 1'b0;
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			if (popup === 1'b1) pop = 1'b1;
		end
	endtask

	task automatic t_reset;
		rd(`REG_CAPACITY);
		chk("capacity", 32'd200, q);
		rd(`REG_READ_NEXT);
		chk("empty read", EMPTY, q);
		$display("test reset done");
	endtask

	task automatic t_link;
		logic [15:0] s;
		ev(6'h01, 6'h02);
		rd(`REG_REREAD);
		s = q[15:0];
		chk("reread code", 32'h0042, {16'h0, q[31:16]});
		rd(`REG_REREAD);
		chk("reread again", {16'h0042, s}, q);
		rd(`REG_READ_NEXT);
		chk("link entry", {16'h0042, s}, q);
		rd(`REG_TIME_HI);
		chk("link stamp hi", 32'h0, q);
		rd(`REG_READ_NEXT);
		chk("after advance", EMPTY, q);
		rd(`REG_READ_NEXT);
		chk("still empty", EMPTY, q);
		rd(`REG_REREAD);
		chk("reread after", {16'h0042, s}, q);
		$display("test link done");
	endtask

	// Stamp difference follows elapsed cycles at one count per ms
	task automatic t_stamp;
		int c0;
		int dc;
		int ds;
		logic [15:0] s0;
		c0 = cyc;
		ev(6'h01, 6'h03);
		rd(`REG_REREAD);
		s0 = q[15:0];
		repeat (30) @(posedge clk);
		dc = cyc - c0;
		ev(6'h01, 6'h04);
		rd(`REG_REREAD);
		ds = int'(q[15:0] - s0) * MSD;
		chk("stamp step", 32'h1,
			{31'h0, ds >= dc - MSD && ds <= dc + MSD});
		rd(`REG_READ_NEXT);
		rd(`REG_READ_NEXT);
		$display("test stamp done");
	endtask

	task automatic t_mask;
		wr(`REG_EVENT_MASK, 32'h8);
		ev(6'h03, 6'h01);
		rd(`REG_READ_NEXT);
		chk("masked dropped", EMPTY, q);
		ev(6'h04, 6'h01);
		rd(`REG_READ_NEXT);
		chk("unmasked kept", 32'h0101, {16'h0, q[31:16]});
		wr(`REG_EVENT_MASK, 32'h0);
		$display("test mask done");
	endtask

	task automatic t_fmt;
		wr(`REG_CTRL, 32'h7);
		time_synced <= 1'b0;
		ev(6'h02, 6'h05);
		chk("popup on", 32'h1, {31'h0, pop});
		rd(`REG_REREAD);
		chk("bracket scale", 32'h3085, {16'h0, q[31:16]});
		time_synced <= 1'b1;
		wr(`REG_CTRL, 32'h0);
		ev(6'h02, 6'h06);
		chk("popup off", 32'h0, {31'h0, pop});
		rd(`REG_REREAD);
		chk("plain format", 32'h0086, {16'h0, q[31:16]});
		$display("test format done");
	endtask

	task automatic t_cap;
		wr(`REG_CAPACITY, 32'd50);
		rd(`REG_CAPACITY);
		chk("cap 50", 32'd50, q);
		rd(`REG_READ_NEXT);
		chk("cleared", EMPTY, q);
		wr(`REG_CAPACITY, 32'd49);
		wr(`REG_CAPACITY, 32'd2001);
		rd(`REG_CAPACITY);
		chk("cap refused", 32'd50, q);
		wr(`REG_CAPACITY, 32'd2000);
		rd(`REG_CAPACITY);
		chk("cap 2000", 32'd2000, q);
		wr(`REG_CAPACITY, 32'd50);
		$display("test capacity done");
	endtask

	task automatic t_ovf;
		int i;
		wr(`REG_IRQ_MASK, 32'h0);
		wr(`REG_IRQ_STATUS, 32'h3);
		for (i = 0; i <= 50; i++) ev(6'h01, 6'(i));
		rd(`REG_COUNT);
		chk("count full", 32'd50, q);
		rd(`REG_REREAD);
		chk("newest kept", 32'h0072, {16'h0, q[31:16]});
		rd(`REG_IRQ_STATUS);
		chk("ovf status", 32'h1, {31'h0, q[`IRQ_OVF_BIT]});
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`REG_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq up", 32'h1, {31'h0, irq});
		wr(`REG_IRQ_STATUS, 32'h3);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test overflow done");
	endtask

	// Display cursor walks both ways, link pointer stays put
	task automatic t_disp;
		rd(`REG_DISP_DATA);
		chk("disp newest", 32'h4072, {16'h0, q[31:16]});
		wr(`REG_DISP_CMD, 32'h1);
		rd(`REG_DISP_DATA);
		chk("disp forward", 32'h0041, {16'h0, q[31:16]});
		wr(`REG_DISP_CMD, 32'h2);
		wr(`REG_DISP_CMD, 32'h2);
		rd(`REG_DISP_DATA);
		chk("disp back wrap", 32'h0071, {16'h0, q[31:16]});
		rd(`REG_READ_NEXT);
		chk("link apart", 32'h0041, {16'h0, q[31:16]});
		wr(`REG_CTRL, 32'h8);
		rd(`REG_COUNT);
		chk("clear count", 32'h0, q);
		$display("test display done");
	endtask

	// Verdict and end of run
	task automatic end_of_test;
		fail_count += i_poll_master.timeouts;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_link;
		t_stamp;
		t_mask;
		t_fmt;
		t_cap;
		t_ovf;
		t_disp;
		end_of_test;
	end
endmodule
